// >>> core/vbi_framer_pkg.sv
// constants, encodings and register map shared by the ancillary packet framer
package vbi_framer_pkg;
	// ---------------------------------------------------------------
	// sizes
	// ---------------------------------------------------------------
	localparam int PAY_MAX = 64;
	localparam int PAY_AW = 6;
	localparam int FIFO_AW = 9;
	localparam logic [9:0] FIFO_DEPTH = 10'h200;
	localparam int LINE_AW = 5;
	localparam int LINE_ENTRIES = 32;
	// ---------------------------------------------------------------
	// packet bytes
	// ---------------------------------------------------------------
	localparam logic [7:0] PREAMBLE_ZERO = 8'h00;
	localparam logic [7:0] PREAMBLE_ONES = 8'hFF;
	localparam logic [7:0] FILL_BYTE = 8'h00;
	localparam logic [7:0] DID_FIELD1 = 8'h91;
	localparam logic [7:0] DID_FIELD1_LATE = 8'h53;
	localparam logic [7:0] DID_FIELD2 = 8'h55;
	localparam logic [7:0] DID_FIELD2_LATE = 8'h97;
	localparam logic [9:0] LATE_LINE = 10'h018;
	localparam logic [6:0] HEADER_BYTES = 7'h08;
	// ---------------------------------------------------------------
	// teletext line windows and byte counts
	// ---------------------------------------------------------------
	localparam logic [9:0] TTX_FIRST_LINE = 10'h006;
	localparam logic [9:0] WST_A_LAST_LINE = 10'h017;
	localparam logic [9:0] WST_B_LAST_LINE = 10'h016;
	localparam logic [6:0] WST_A_BYTES = 7'h26;
	localparam logic [6:0] WST_B_BYTES = 7'h2B;
	// ---------------------------------------------------------------
	// service formats held in the per-line table
	// ---------------------------------------------------------------
	typedef logic [2:0] fmt_type;
	localparam fmt_type FMT_OFF = 3'h0;
	localparam fmt_type FMT_WST_A = 3'h1;
	localparam fmt_type FMT_WST_B = 3'h2;
	localparam fmt_type FMT_NABTS_C = 3'h3;
	localparam fmt_type FMT_NABTS_D = 3'h4;
	localparam fmt_type FMT_CC = 3'h5;
	localparam fmt_type FMT_WSS = 3'h6;
	localparam fmt_type FMT_USER = 3'h7;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_FIFO_DATA = 12'h008;
	localparam logic [11:0] REG_RESULT = 12'h00C;
	localparam logic [4:0] REG_LINE_PAGE = 5'h01;
	localparam int CTRL_STREAM_BIT = 0;
	localparam int CTRL_FIFO_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DROP_BIT = 1;
	localparam int STATUS_LEVEL_LSB = 16;
	localparam int FIFO_VALID_BIT = 8;
	// ---------------------------------------------------------------
	// framer states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_COLLECT = 3'b010,
		ST_EMIT = 3'b100
	} state_type;
endpackage : vbi_framer_pkg

// >>> core/fifo_port_if.sv
// byte push and pop port between the framer and its result buffer
`timescale 1ns/1ps
interface fifo_port_if;
	logic push;
	logic [7:0] push_data;
	logic pop;
	logic [7:0] pop_data;
	logic empty;
	logic [9:0] level;
	modport fifo (input push, input push_data, input pop, output pop_data, output empty,
		output level);
	modport user (output push, output push_data, output pop, input pop_data, input empty,
		input level);
endinterface : fifo_port_if

// >>> core/vbi_result_fifo.sv
// 512-byte result buffer in flip-flops
`timescale 1ns/1ps
module vbi_result_fifo
	import vbi_framer_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	fifo_port_if.fifo port
);
	logic [7:0] mem_q [0:FIFO_DEPTH-1];
	logic [FIFO_AW-1:0] wr_ptr_q;
	logic [FIFO_AW-1:0] rd_ptr_q;
	logic [9:0] level_q;
	logic do_push;
	logic do_pop;

	// a push into a full buffer is dropped; the framer checks space first
	assign do_push = port.push && (level_q != FIFO_DEPTH);
	assign do_pop = port.pop && (level_q != 10'h000);
	assign port.pop_data = mem_q[rd_ptr_q];
	assign port.empty = (level_q == 10'h000);
	assign port.level = level_q;

	// storage write
	always_ff @(posedge core_clk) begin
		if (do_push) begin
			mem_q[wr_ptr_q] <= port.push_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			level_q <= 10'h000;
		end else begin
			if (do_push) begin
				wr_ptr_q <= wr_ptr_q + 9'h001;
			end
			if (do_pop) begin
				rd_ptr_q <= rd_ptr_q + 9'h001;
			end
			if (do_push && !do_pop) begin
				level_q <= level_q + 10'h001;
			end else if (do_pop && !do_push) begin
				level_q <= level_q - 10'h001;
			end
		end
	end
endmodule : vbi_result_fifo

// >>> core/line_mode_table.sv
// per-line service format table with one write and two read ports
`timescale 1ns/1ps
module line_mode_table
	import vbi_framer_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [LINE_AW-1:0] wr_index,
	input wire vbi_framer_pkg::fmt_type wr_format,
	input wire logic [LINE_AW-1:0] rd_index_a,
	output vbi_framer_pkg::fmt_type rd_format_a,
	input wire logic [LINE_AW-1:0] rd_index_b,
	output vbi_framer_pkg::fmt_type rd_format_b
);
	fmt_type entry_q [0:LINE_ENTRIES-1];

	// every line starts with no service
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < LINE_ENTRIES; i++) begin
				entry_q[i] <= FMT_OFF;
			end
		end else if (wr_en) begin
			entry_q[wr_index] <= wr_format;
		end
	end

	assign rd_format_a = entry_q[rd_index_a];
	assign rd_format_b = entry_q[rd_index_b];
endmodule : line_mode_table

// >>> core/vbi_ancillary_packet_framer.sv
// sliced data packet framer: stream insertion, result buffer and APB registers
//
// What this block does
// - packet bytes go out on luma bits 9..2 during horizontal blanking
// - one packet layout for stream insertion and for the result buffer
// - result buffer holds 512 bytes
// - teletext goes to the stream and the buffer, never to the result register
// - service format is chosen per video line for lines 0..30, lines 31 on share one entry; one service per line
// - bytes 0..2 are 00h FFh FFh; byte 3 parity, 010, three-bit id
// - id, format and count bytes: bit6 even parity of 5..0, bit7 inverted
// - id 91h for first field lines, 55h for second field lines
// - id 53h from line 24 on in field one, 97h in field two
// - byte 4 carries the line's three-bit service format
// - byte 5 counts 32-bit words from byte 8 to the packet end
// - byte 6 line number bits 7..0; byte 7 bits 1..0 hold bits 9..8
// - byte 7 bit 2 second match, bit 3 first match, bits 7..5 zero
// - byte 7 bit 4 set when the error check stage flagged the line
// - checksum after payload is the 8-bit sum of all payload bytes
// - 00h fill bytes pad the packet to a multiple of four bytes
// - teletext: byte 8 is the sync pattern, byte 9 first data byte
// - system A teletext accepted on lines 6..23 with 38 bytes
// - system B teletext accepted on lines 6..22 with 43 bytes
// - packets appear on the stream only outside the active video window
`timescale 1ns/1ps
module vbi_ancillary_packet_framer
	import vbi_framer_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [9:0] video_line,
	output vbi_framer_pkg::fmt_type slicer_format,
	input wire logic slice_start,
	input wire logic slice_field,
	input wire logic [9:0] slice_line,
	input wire logic slice_match1,
	input wire logic slice_match2,
	input wire logic slice_error,
	input wire logic slice_byte_valid,
	input wire logic [7:0] slice_byte,
	input wire logic slice_end,
	input wire logic active_video_qualifier,
	output logic [9:0] anc_luma,
	output logic anc_luma_valid
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// parity-protected byte: bit6 even parity, bit7 its inverse
	function automatic logic [7:0] parity_byte(input logic [5:0] v);
		parity_byte = {~(^v), ^v, v};
	endfunction : parity_byte

	// line number folded onto the 32-entry table; late lines share the last
	function automatic logic [LINE_AW-1:0] line_index(input logic [9:0] line);
		if (line < 10'h020) begin
			line_index = line[LINE_AW-1:0];
		end else begin
			line_index = 5'h1F;
		end
	endfunction : line_index

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	state_type state_q;
	logic [1:0] ctrl_q;
	logic drop_q;
	logic [31:0] result_q;
	logic [7:0] pay_q [0:PAY_MAX-1];
	logic [6:0] count_q;
	logic overrun_q;
	logic [7:0] csum_q;
	logic [9:0] line_q;
	logic field_q;
	logic match1_q;
	logic match2_q;
	logic error_q;
	fmt_type fmt_q;
	logic [6:0] len_q;
	logic [5:0] words_q;
	logic [6:0] idx_q;
	logic fifo_ok_q;
	logic stream_ok_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	fmt_type slicer_format_q;
	logic [9:0] anc_luma_q;
	logic anc_luma_valid_q;

	fifo_port_if fifo_port ();
	fmt_type lookup_fmt;
	fmt_type start_fmt;
	logic [7:0] cur_byte;
	logic [7:0] did_byte;
	logic advance;
	logic last_byte;
	logic is_ttx;
	logic ttx_ok;
	logic [6:0] len_raw;
	logic [6:0] len_d;
	logic [9:0] free_space;
	logic apb_access;
	logic apb_done;
	logic line_hit;
	logic drop_now;

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign slicer_format = slicer_format_q;
	assign anc_luma = anc_luma_q;
	assign anc_luma_valid = anc_luma_valid_q;

	// ---------------------------------------------------------------
	// submodules
	// ---------------------------------------------------------------
	vbi_result_fifo u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.port(fifo_port.fifo)
	);

	line_mode_table u_lines (
		.core_clk(core_clk),
		.rst(rst),
		.wr_en(apb_done && pwrite && line_hit),
		.wr_index(paddr[6:2]),
		.wr_format(pwdata[2:0]),
		.rd_index_a(line_index(video_line)),
		.rd_format_a(lookup_fmt),
		.rd_index_b(line_index(slice_line)),
		.rd_format_b(start_fmt)
	);

	// ---------------------------------------------------------------
	// packet length and acceptance
	// ---------------------------------------------------------------
	// header, payload and checksum, rounded up to whole words
	assign len_raw = HEADER_BYTES + count_q + 7'h01;
	assign len_d = (len_raw + 7'h03) & 7'h7C;
	assign is_ttx = (fmt_q == FMT_WST_A) || (fmt_q == FMT_WST_B)
		|| (fmt_q == FMT_NABTS_C) || (fmt_q == FMT_NABTS_D);
	assign free_space = FIFO_DEPTH - fifo_port.level;

	// system A and B teletext lines outside their window or with a wrong count are refused
	always_comb begin
		ttx_ok = 1'b1;
		if (fmt_q == FMT_WST_A) begin
			ttx_ok = (line_q >= TTX_FIRST_LINE) && (line_q <= WST_A_LAST_LINE)
				&& (count_q == WST_A_BYTES);
		end else if (fmt_q == FMT_WST_B) begin
			ttx_ok = (line_q >= TTX_FIRST_LINE) && (line_q <= WST_B_LAST_LINE)
				&& (count_q == WST_B_BYTES);
		end
	end

	// ---------------------------------------------------------------
	// packet byte generator
	// ---------------------------------------------------------------
	always_comb begin
		if (line_q >= LATE_LINE) begin
			did_byte = field_q ? DID_FIELD2_LATE : DID_FIELD1_LATE;
		end else begin
			did_byte = field_q ? DID_FIELD2 : DID_FIELD1;
		end
	end

	// one layout for both destinations, indexed by the byte counter
	always_comb begin
		cur_byte = FILL_BYTE;
		case (idx_q)
			7'h00: cur_byte = PREAMBLE_ZERO;
			7'h01: cur_byte = PREAMBLE_ONES;
			7'h02: cur_byte = PREAMBLE_ONES;
			7'h03: cur_byte = did_byte;
			7'h04: cur_byte = parity_byte({3'h0, fmt_q});
			7'h05: cur_byte = parity_byte(words_q);
			7'h06: cur_byte = line_q[7:0];
			7'h07: cur_byte = {3'h0, error_q, match1_q, match2_q, line_q[9:8]};
			default: begin
				// teletext sync byte arrives first from the slicer, so lands in byte 8
				if (idx_q < HEADER_BYTES + count_q) begin
					cur_byte = pay_q[idx_q[PAY_AW-1:0] - 6'h08];
				end else if (idx_q == HEADER_BYTES + count_q) begin
					cur_byte = csum_q;
				end
			end
		endcase
	end

	// stream output waits while the active window is open
	assign advance = (state_q == ST_EMIT) && (!stream_ok_q || !active_video_qualifier);
	assign last_byte = (idx_q == len_q - 7'h01);
	assign fifo_port.push = advance && fifo_ok_q;
	assign fifo_port.push_data = cur_byte;

	// ---------------------------------------------------------------
	// framer sequence
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			idx_q <= 7'h00;
			len_q <= 7'h00;
			words_q <= 6'h00;
			fifo_ok_q <= 1'b0;
			stream_ok_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (slice_start && start_fmt != FMT_OFF) begin
						state_q <= ST_COLLECT;
					end
				end
				ST_COLLECT: begin
					if (slice_end) begin
						len_q <= len_d;
						words_q <= {1'b0, len_d[6:2]} - 6'h02;
						idx_q <= 7'h00;
						// whole packet or nothing into the buffer
						fifo_ok_q <= ctrl_q[CTRL_FIFO_BIT]
							&& ({3'h0, len_d} <= free_space);
						// teletext stays off the result register but may be streamed
						stream_ok_q <= ctrl_q[CTRL_STREAM_BIT];
						if (!overrun_q && ttx_ok && (ctrl_q != 2'h0)) begin
							state_q <= ST_EMIT;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_EMIT: begin
					if (advance) begin
						idx_q <= idx_q + 7'h01;
						if (last_byte) begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// line header capture at the start of a sliced line
	always_ff @(posedge core_clk) begin
		if (rst) begin
			line_q <= 10'h000;
			field_q <= 1'b0;
			match1_q <= 1'b0;
			match2_q <= 1'b0;
			error_q <= 1'b0;
			fmt_q <= FMT_OFF;
		end else if (state_q == ST_IDLE && slice_start) begin
			line_q <= slice_line;
			field_q <= slice_field;
			match1_q <= slice_match1;
			match2_q <= slice_match2;
			error_q <= slice_error;
			fmt_q <= start_fmt;
		end
	end

	// payload capture with running checksum
	always_ff @(posedge core_clk) begin
		if (rst) begin
			count_q <= 7'h00;
			csum_q <= 8'h00;
			overrun_q <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			count_q <= 7'h00;
			csum_q <= 8'h00;
			overrun_q <= 1'b0;
		end else if (state_q == ST_COLLECT && slice_byte_valid) begin
			if (count_q < 7'h40) begin
				pay_q[count_q[PAY_AW-1:0]] <= slice_byte;
				count_q <= count_q + 7'h01;
				csum_q <= csum_q + slice_byte;
			end else begin
				overrun_q <= 1'b1;
			end
		end
	end

	// luma bus: packet byte on bits 9..2, low bits zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			anc_luma_q <= 10'h000;
			anc_luma_valid_q <= 1'b0;
		end else if (advance && stream_ok_q) begin
			anc_luma_q <= {cur_byte, 2'h0};
			anc_luma_valid_q <= 1'b1;
		end else begin
			anc_luma_q <= 10'h000;
			anc_luma_valid_q <= 1'b0;
		end
	end

	// format for the line now being sliced
	always_ff @(posedge core_clk) begin
		if (rst) begin
			slicer_format_q <= FMT_OFF;
		end else begin
			slicer_format_q <= lookup_fmt;
		end
	end

	// first payload bytes of non-teletext lines
	always_ff @(posedge core_clk) begin
		if (rst) begin
			result_q <= 32'h0000_0000;
		end else if (state_q == ST_COLLECT && slice_end && !is_ttx && !overrun_q) begin
			result_q <= {pay_q[3], pay_q[2], pay_q[1], pay_q[0]};
		end
	end

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	// one wait state so read data comes from a flop
	assign apb_access = psel && penable;
	assign apb_done = apb_access && pready_q;
	assign line_hit = (paddr[11:7] == REG_LINE_PAGE) && (paddr[1:0] == 2'h0);
	// refused lines: busy framer, payload overrun, bad teletext line or buffer without room
	assign drop_now = (state_q == ST_IDLE && slice_start && start_fmt == FMT_OFF) ? 1'b0
		: (slice_start && state_q != ST_IDLE)
		|| (state_q == ST_COLLECT && slice_end && (overrun_q || !ttx_ok))
		|| (state_q == ST_COLLECT && slice_end && ctrl_q[CTRL_FIFO_BIT]
			&& ({3'h0, len_d} > free_space));
	assign fifo_port.pop = apb_done && !pwrite && (paddr == REG_FIFO_DATA);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= apb_access && !pready_q;
		end
	end

	// read data and error are set up in the first access cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (apb_access && !pready_q) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
			if (line_hit) begin
				prdata_q <= {29'h0, start_fmt};
			end else begin
				case (paddr)
					REG_CTRL: prdata_q <= {30'h0, ctrl_q};
					REG_STATUS: begin
						prdata_q[STATUS_BUSY_BIT] <= (state_q != ST_IDLE);
						prdata_q[STATUS_DROP_BIT] <= drop_q;
						prdata_q[STATUS_LEVEL_LSB +: 10] <= fifo_port.level;
					end
					REG_FIFO_DATA: begin
						prdata_q[FIFO_VALID_BIT] <= !fifo_port.empty;
						prdata_q[7:0] <= fifo_port.empty ? 8'h00 : fifo_port.pop_data;
					end
					REG_RESULT: prdata_q <= result_q;
					default: pslverr_q <= 1'b1;
				endcase
			end
		end else begin
			pslverr_q <= 1'b0;
		end
	end

	// control register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
		end else if (apb_done && pwrite && paddr == REG_CTRL) begin
			ctrl_q <= pwdata[1:0];
		end
	end

	// sticky drop flag, write one to clear; a new drop wins over the clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			drop_q <= 1'b0;
		end else if (drop_now) begin
			drop_q <= 1'b1;
		end else if (apb_done && pwrite && paddr == REG_STATUS && pwdata[STATUS_DROP_BIT]) begin
			drop_q <= 1'b0;
		end
	end
endmodule : vbi_ancillary_packet_framer

// >>> testbench/framer_port_chk.sv
// port checker for the ancillary packet framer
`timescale 1ns/1ps
module framer_port_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic active_video_qualifier,
	input wire logic [9:0] anc_luma,
	input wire logic anc_luma_valid
);
	// ------
	// byte position inside the packet
	// ------
	logic [6:0] idx_q;
	logic [7:0] len_q;
	logic [7:0] pb;
	logic last;
	assign pb = anc_luma[9:2];
	assign last = idx_q > 7'h05 && {1'b0, idx_q} == len_q - 8'h01;
	// restarts after the last byte, so a stall keeps the place
	always_ff @(posedge core_clk) begin
		if (rst || (anc_luma_valid && last)) begin
			idx_q <= 7'h00;
		end else if (anc_luma_valid) begin
			idx_q <= idx_q + 7'h01;
		end
	end
	// length taken from the word count byte
	always_ff @(posedge core_clk) begin
		if (rst) begin
			len_q <= 8'hFF;
		end else if (anc_luma_valid && idx_q == 7'h05) begin
			len_q <= {pb[5:0], 2'h0} + 8'h08;
		end
	end
	// ------
	// assertions
	// ------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence access_open;
		psel && penable && !$past(penable);
	endsequence
	sequence answer_late;
		!pready ##1 pready;
	endsequence
	apb_answer_a: assert property (access_open |-> answer_late) else $error("apb answer late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	slverr_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("slverr");
	luma_idle_a: assert property (anc_luma[1:0] == 2'h0 && (anc_luma_valid || anc_luma == 10'h000))
		else $error("luma idle");
	blank_only_a: assert property (anc_luma_valid |->
		!$past(active_video_qualifier)) else $error("active");
	preamble_zero_a: assert property (anc_luma_valid && idx_q == 7'h00 |-> pb == 8'h00)
		else $error("preamble 0");
	preamble_ones_a: assert property (anc_luma_valid && idx_q inside {1, 2} |-> pb == 8'hFF)
		else $error("preamble 1");
	type_id_a: assert property (anc_luma_valid && idx_q == 7'h03 |->
		pb inside {8'h91, 8'h53, 8'h55, 8'h97}) else $error("type id");
	id_parity_a: assert property (anc_luma_valid && idx_q inside {3, 4, 5} |->
		pb[6] == ^pb[5:0] && pb[7] == !pb[6]) else $error("parity");
	format_byte_a: assert property (anc_luma_valid && idx_q == 7'h04 |->
		pb[5:3] == 3'h0 && pb[2:0] != 3'h0) else $error("format byte");
	flags_zero_a: assert property (anc_luma_valid && idx_q == 7'h07 |-> pb[7:5] == 3'h0)
		else $error("flags");
	reset_quiet_a: assert property (disable iff (1'b0) rst |=> !pready && !pslverr && !anc_luma_valid)
		else $error("reset");
endmodule : framer_port_chk
bind vbi_ancillary_packet_framer framer_port_chk u_framer_port_chk (
	.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .active_video_qualifier(active_video_qualifier),
	.anc_luma(anc_luma), .anc_luma_valid(anc_luma_valid)
);

// >>> testbench/vbi_capture_model.sv
// capture side model: finds ancillary packets in the luma stream
`timescale 1ns/1ps
module vbi_capture_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [9:0] anc_luma,
	input wire logic anc_luma_valid
);
	// ------
	// packet capture
	// ------
	logic [7:0] pkt [0:127];
	logic [7:0] bv;
	int idx, pkt_len, pkt_count, bad_count;
	// resync on the preamble, end found from the word count
	always @(posedge core_clk) begin
		bv = anc_luma[9:2];
		if (rst) begin
			idx = 0;
			pkt_count = 0;
			bad_count = 0;
		end else if (anc_luma_valid) begin
			if (idx < 3 && bv != (idx == 0 ? 8'h00 : 8'hFF)) begin
				idx = 0;
			end else begin
				pkt[idx] = bv;
				if (idx == 5) begin
					pkt_len = 8 + 4 * int'(bv[5:0]);
				end
				if (idx inside {3, 4, 5} && bv[7:6] != {~^bv[5:0], ^bv[5:0]}) begin
					bad_count++;
				end
				idx++;
				if (idx > 7 && idx == pkt_len) begin
					idx = 0;
					pkt_count++;
				end
			end
		end
	end
endmodule : vbi_capture_model

// >>> testbench/testbench.sv
// self-checking bench for the ancillary packet framer
`timescale 1ns/1ps
module testbench;
	import vbi_framer_pkg::*;
	typedef struct {logic f; logic [9:0] ln; fmt_type fm; logic [2:0] fl; int n;} row_type;
	logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rv, res;
	logic pready, pslverr, re, anc_luma_valid;
	logic [9:0] video_line = 10'h000, slice_line = 10'h000, anc_luma;
	fmt_type slicer_format;
	logic slice_start = 1'b0, slice_field = 1'b0, slice_match1 = 1'b0, slice_match2 = 1'b0;
	logic slice_error = 1'b0, slice_byte_valid = 1'b0, slice_end = 1'b0;
	logic active_video_qualifier = 1'b0;
	logic [7:0] slice_byte = 8'h00;
	logic [7:0] xp [0:127];
	int err_count = 0, compares = 0, xlen, c;
	// ordinary lines: field, line, format, {error, match1, match2}, byte count
	row_type rows [8] = '{'{1'b0, 10'h015, FMT_CC, 3'h2, 2}, '{1'b1, 10'h015, FMT_CC, 3'h5, 2},
		'{1'b1, 10'h12C, FMT_WSS, 3'h3, 3}, '{1'b0, 10'h01E, FMT_USER, 3'h0, 5},
		'{1'b0, 10'h006, FMT_WST_A, 3'h0, 38}, '{1'b1, 10'h016, FMT_WST_B, 3'h4, 43},
		'{1'b0, 10'h00C, FMT_NABTS_C, 3'h0, 34}, '{1'b1, 10'h00D, FMT_NABTS_D, 3'h0, 35}};
	row_type bad [2] = '{'{1'b0, 10'h006, FMT_WST_A, 3'h0, 37},
		'{1'b0, 10'h017, FMT_WST_B, 3'h0, 43}};
	// ------
	// design, far side and clock
	// ------
	vbi_ancillary_packet_framer u_vbi_ancillary_packet_framer (
		.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .video_line, .slicer_format, .slice_start, .slice_field, .slice_line,
		.slice_match1, .slice_match2, .slice_error, .slice_byte_valid, .slice_byte,
		.slice_end, .active_video_qualifier, .anc_luma, .anc_luma_valid
	);
	vbi_capture_model u_vbi_capture_model (.core_clk, .rst, .anc_luma, .anc_luma_valid);
	// 40 MHz
	always #12.5 core_clk = ~core_clk;
	// ------
	// tasks
	// ------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	// pready is read at the rising edge that takes it, before that edge updates it
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n = 0;
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge core_clk);
		end
		rv = prdata;
		re = pslverr;
		{psel, penable} <= 2'b00;
		check(32'(n < 20), 32'h1);
	endtask : apb
	task automatic rd(input logic [11:0] a);
		apb(a, 1'b0, 32'h0);
	endtask : rd
	function automatic logic [7:0] par(input logic [5:0] v);
		return {~^v, ^v, v};
	endfunction : par
	task automatic send(input row_type r, input logic [7:0] s);
		@(posedge core_clk);
		{slice_start, slice_field, slice_line} <= {1'b1, r.f, r.ln};
		{slice_error, slice_match1, slice_match2} <= r.fl;
		for (int j = 0; j < r.n; j++) begin
			@(posedge core_clk);
			{slice_start, slice_byte_valid, slice_byte} <= {2'b01, s + 8'(j * 11)};
		end
		@(posedge core_clk);
		{slice_start, slice_byte_valid, slice_end} <= 3'b001;
		@(posedge core_clk);
		slice_end <= 1'b0;
	endtask : send
	task automatic wait_pkt(input int c0);
		int n = 0;
		while (u_vbi_capture_model.pkt_count == c0 && n < 500) begin
			@(posedge core_clk);
			n++;
		end
		check(32'(u_vbi_capture_model.pkt_count), 32'(c0 + 1));
	endtask : wait_pkt
	// expected packet built from the line, then stream and buffer compared, and result for teletext or four or more bytes
	task automatic run_row(input int i);
		row_type r;
		logic [7:0] s;
		logic [7:0] cs;
		r = rows[i];
		s = 8'(i * 16 + 3);
		cs = 8'h00;
		xlen = (r.n + 12) & ~3;
		for (int j = 0; j < xlen; j++) xp[j] = 8'h00;
		{xp[1], xp[2], xp[6], xp[7]} = {16'hFFFF, r.ln[7:0], 3'h0, r.fl, r.ln[9:8]};
		xp[3] = r.ln < 10'h018 ? (r.f ? 8'h55 : 8'h91) : (r.f ? 8'h97 : 8'h53);
		xp[4] = par({3'h0, r.fm});
		xp[5] = par(6'((xlen - 8) / 4));
		for (int j = 0; j < r.n; j++) begin
			xp[8 + j] = s + 8'(j * 11);
			cs = cs + xp[8 + j];
		end
		xp[8 + r.n] = cs;
		c = u_vbi_capture_model.pkt_count;
		send(r, s);
		wait_pkt(c);
		check(32'(u_vbi_capture_model.pkt_len), 32'(xlen));
		for (int j = 0; j < xlen; j++) begin
			check(32'(u_vbi_capture_model.pkt[j]), 32'(xp[j]));
		end
		for (int j = 0; j < xlen; j++) begin
			rd(REG_FIFO_DATA);
			check(rv, {23'h0, 1'b1, xp[j]});
		end
		rd(REG_RESULT);
		if (r.fm inside {[FMT_WST_A:FMT_NABTS_D]}) begin
			check(rv, res);
		end else if (r.n >= 4) begin
			res = {xp[11], xp[10], xp[9], xp[8]};
			check(rv, res);
		end
	endtask : run_row
	// ------
	// sequence
	// ------
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd(REG_CTRL);
		check(rv, 32'h2);
		rd(12'h040);
		check({re, rv[30:0]}, 32'h80000000);
		apb(REG_CTRL, 1'b1, 32'h3);
		foreach (rows[i]) apb(12'(128 + 4 * (rows[i].ln < 31 ? rows[i].ln : 31)), 1'b1, 32'(rows[i].fm));
		apb(12'h0DC, 1'b1, 32'(FMT_WST_B));
		video_line <= 10'h015;
		repeat (3) @(posedge core_clk);
		check(32'(slicer_format), 32'(FMT_CC));
		$display("registers done");
		foreach (rows[i]) run_row(i);
		$display("rows done");
		fork
			run_row(6);
			begin
				repeat (45) @(posedge core_clk);
				active_video_qualifier <= 1'b1;
				repeat (10) @(posedge core_clk);
				active_video_qualifier <= 1'b0;
			end
		join
		$display("stall done");
		for (int k = 0; k < 2; k++) begin
			c = u_vbi_capture_model.pkt_count;
			send(bad[k], 8'h11);
			repeat (80) @(posedge core_clk);
			check(32'(u_vbi_capture_model.pkt_count), 32'(c));
			rd(REG_STATUS);
			check(rv, 32'h2);
			apb(REG_STATUS, 1'b1, 32'h2);
			rd(REG_STATUS);
			check(rv, 32'h0);
		end
		$display("refusals done");
		for (int k = 0; k < 12; k++) begin
			c = u_vbi_capture_model.pkt_count;
			send(rows[6], 8'h40);
			wait_pkt(c);
		end
		rd(REG_STATUS);
		check(rv, {6'h0, 10'h1E4, 14'h0, 2'h2});
		for (int k = 0; k < 484; k++) rd(REG_FIFO_DATA);
		check(rv, 32'h100);
		rd(REG_FIFO_DATA);
		check({31'h0, rv[8]}, 32'h0);
		check(32'(u_vbi_capture_model.bad_count), 32'h0);
		$display("buffer done");
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rd(REG_CTRL);
		check(rv, 32'h2);
		rd(REG_STATUS);
		check(rv, 32'h0);
		$display("reset done");
		stop_test();
	end
	// watchdog: the whole sequence needs under ten thousand cycles
	initial begin
		repeat (40000) @(posedge core_clk);
		$display("watchdog expired");
		err_count++;
		stop_test();
	end
endmodule : testbench
